//--- inc/eciv_pkg.sv
// How it works
// [RQ1] iv is computed whenever an envelope header is seen on a channel
// [RQ2] iv computed in one cycle; low 6 clock bits match header marker
// [RQ3] headend encrypt iv: channel, own mac, cipher_clock_a, block zero
// [RQ4] headend decrypt iv: channel, mac table by llid, cipher_clock_a, block zero
// [RQ5] terminal encrypt iv: channel, own mac, cipher_clock_a, block zero
// [RQ6] terminal decrypt iv: channel, learned headend mac, rx_cipher_clock_c, block zero
// [RQ7] payload split into 128-bit blocks, plaintext or ciphertext
// [RQ8] two payload quanta per block; odd payload ends with single-quantum block
// [RQ9] grouping starts after header; header never encrypted
// [RQ10] rate-adjust quanta bypass, not counted, do not advance alignment
// [RQ11] inter-envelope idle quanta bypass and leave alignment alone
// [RQ12] inter-burst idle quanta bypass and leave alignment alone
// [RQ13] terminate and idle control characters pass unchanged
// [RQ14] keystream is ANDed with mask before the xor
// [RQ15] octet with control flag 1 stays clear, flag 0 is encrypted
// [RQ16] mask octet ff for data, 00 for control
// [RQ17] two 64-bit quantum masks concatenate into one 128-bit mask
// [RQ18] cipher_clock_a is 16 extension bits above 32-bit local time
// [RQ19] rx_cipher_clock_c is a separate 48-bit counter stepping with mpcp clock
// [RQ20] header marker field is set from low 6 bits of local time
// [RQ21] first quantum in upper 64 bits; missing half masked to zero
// [RQ22] block index increments per block, restarts at zero on header
package eciv_pkg;
  localparam int CH_W = 4;
  localparam int LLID_W = 4;
  localparam int MAC_W = 48;
  localparam int CLK_W = 48;
  localparam int LT_W = 32;
  localparam int MARK_W = 6;
  localparam int BLK_W = 16;
  localparam int Q_W = 64;
  localparam int B_W = 128;
  localparam logic [47:0] CLK_RST = 48'h0;
  localparam logic [BLK_W-1:0] BLK_RST = 16'h0;
  localparam logic [7:0] OCT_DATA = 8'hff;
  localparam logic [7:0] OCT_CTRL = 8'h00;

  typedef enum logic [1:0] {ECIV_HE_ENC, ECIV_HE_DEC, ECIV_TE_ENC, ECIV_TE_DEC} eciv_role_t;
  typedef enum logic [2:0] {
    ECIV_Q_HEADER, ECIV_Q_PAYLOAD, ECIV_Q_RATE_ADJUST, ECIV_Q_IEI, ECIV_Q_IBI
  } eciv_qkind_t;

  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [MAC_W-1:0] mac;
    logic [CLK_W-1:0] iv_time_field;
    logic [BLK_W-1:0] iv_block_field;
  } eciv_iv_t;

  typedef struct packed {
    logic valid;
    eciv_qkind_t kind;
    logic [CH_W-1:0] ch;
    logic [LLID_W-1:0] llid;
    logic last;
    logic [7:0] ctrl;
    logic [Q_W-1:0] data;
  } eciv_quantum_t;

  typedef struct packed {
    logic valid;
    logic start;
    logic single;
    eciv_iv_t iv;
    logic [B_W-1:0] block;
    logic [B_W-1:0] mask;
  } eciv_block_t;

  typedef struct packed {
    logic valid;
    eciv_qkind_t kind;
    logic [7:0] ctrl;
    logic [Q_W-1:0] data;
  } eciv_pass_t;
endpackage

//--- verilog/eciv_core.sv
`timescale 1ns/1ns
module eciv_core
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire eciv_pkg::eciv_role_t role,
  input wire logic [eciv_pkg::MAC_W-1:0] own_mac,
  input wire logic [eciv_pkg::MAC_W-1:0] learned_headend_mac,
  input wire logic mac_wr,
  input wire logic [eciv_pkg::LLID_W-1:0] mac_wr_llid,
  input wire logic [eciv_pkg::MAC_W-1:0] mac_wr_data,
  input wire logic rx_clock_load,
  input wire logic [eciv_pkg::CLK_W-1:0] rx_clock_value,
  input wire logic tx_ext_load,
  input wire logic [15:0] tx_ext_value,
  input wire eciv_pkg::eciv_quantum_t q_in,
  input wire logic [eciv_pkg::B_W-1:0] keystream,
  input wire logic keystream_valid,
  output eciv_pkg::eciv_block_t blk_out,
  output eciv_pkg::eciv_pass_t pass_out,
  output logic [eciv_pkg::B_W-1:0] cipher_out,
  output logic cipher_out_valid,
  output logic [eciv_pkg::MARK_W-1:0] local_marker,
  output logic [eciv_pkg::LT_W-1:0] local_time,
  output logic [eciv_pkg::CLK_W-1:0] cipher_clock_a
);
  typedef struct packed {
    logic [eciv_pkg::CLK_W-1:0] clk_a;
    logic [eciv_pkg::CLK_W-1:0] clk_c;
    eciv_pkg::eciv_iv_t iv;
    logic in_env;
    logic half;
    logic [eciv_pkg::Q_W-1:0] hi_data;
    logic [eciv_pkg::Q_W-1:0] hi_mask;
    eciv_pkg::eciv_block_t blk;
    eciv_pkg::eciv_pass_t pass;
    logic [eciv_pkg::B_W-1:0] cout;
    logic cvalid;
    logic [eciv_pkg::MARK_W-1:0] mark;
  } eciv_state_t;

  eciv_state_t st_ff;
  eciv_state_t nxt_st;
  logic [eciv_pkg::MAC_W-1:0] mac_tab_ff [2**eciv_pkg::LLID_W];
  logic [eciv_pkg::Q_W-1:0] qmask;

  // per-octet mask from control flags
  function automatic logic [eciv_pkg::Q_W-1:0] oct_mask(input logic [7:0] ctrl);
    logic [eciv_pkg::Q_W-1:0] m;
    m = '0;
    for (int i = 0; i < 8; i++)
    begin
      m[eciv_pkg::Q_W-1-8*i -: 8] = ctrl[7-i] ? eciv_pkg::OCT_CTRL : eciv_pkg::OCT_DATA; // RQ15
    end
    return m; // RQ16
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (mac_wr)
    begin
      mac_tab_ff[mac_wr_llid] <= mac_wr_data;
    end
  end

  always_comb
  begin
    qmask = oct_mask(q_in.ctrl); // RQ13
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.clk_a = st_ff.clk_a + 48'h1; // RQ18
    if (tx_ext_load)
    begin
      nxt_st.clk_a = {tx_ext_value, st_ff.clk_a[31:0] + 32'h1};
    end
    nxt_st.clk_c = st_ff.clk_c + 48'h1; // RQ19
    if (rx_clock_load)
    begin
      nxt_st.clk_c = rx_clock_value;
    end
    nxt_st.mark = nxt_st.clk_a[eciv_pkg::MARK_W-1:0]; // RQ20
    nxt_st.blk.valid = 1'b0;
    nxt_st.blk.start = 1'b0;
    nxt_st.pass = '0;
    nxt_st.cvalid = 1'b0;
    if (keystream_valid && st_ff.blk.valid)
    begin
      nxt_st.cout = st_ff.blk.block ^ (keystream & st_ff.blk.mask); // RQ14
      nxt_st.cvalid = 1'b1;
    end
    if (q_in.valid)
    begin
      case (q_in.kind)
        eciv_pkg::ECIV_Q_HEADER:
        begin
          // header itself passes clear and restarts grouping
          nxt_st.pass = {1'b1, q_in.kind, q_in.ctrl, q_in.data}; // RQ9
          nxt_st.in_env = 1'b1;
          nxt_st.half = 1'b0;
          nxt_st.iv.ch = q_in.ch; // RQ1
          nxt_st.iv.iv_block_field = eciv_pkg::BLK_RST; // RQ22
          case (role)
            eciv_pkg::ECIV_HE_ENC:
            begin
              nxt_st.iv.mac = own_mac; // RQ3
              nxt_st.iv.iv_time_field = st_ff.clk_a; // RQ2
            end
            eciv_pkg::ECIV_HE_DEC:
            begin
              nxt_st.iv.mac = mac_tab_ff[q_in.llid]; // RQ4
              nxt_st.iv.iv_time_field = st_ff.clk_a;
            end
            eciv_pkg::ECIV_TE_ENC:
            begin
              nxt_st.iv.mac = own_mac; // RQ5
              nxt_st.iv.iv_time_field = st_ff.clk_a;
            end
            default:
            begin
              nxt_st.iv.mac = learned_headend_mac; // RQ6
              nxt_st.iv.iv_time_field = st_ff.clk_c;
            end
          endcase
        end
        eciv_pkg::ECIV_Q_PAYLOAD:
        begin
          if (st_ff.in_env)
          begin
            if (!st_ff.half && !q_in.last)
            begin
              nxt_st.hi_data = q_in.data; // RQ21
              nxt_st.hi_mask = qmask;
              nxt_st.half = 1'b1;
            end
            else
            begin
              nxt_st.blk.valid = 1'b1; // RQ7
              nxt_st.blk.iv = st_ff.iv;
              if (st_ff.half)
              begin
                nxt_st.blk.single = 1'b0;
                nxt_st.blk.block = {st_ff.hi_data, q_in.data}; // RQ8
                nxt_st.blk.mask = {st_ff.hi_mask, qmask}; // RQ17
              end
              else
              begin
                nxt_st.blk.single = 1'b1;
                nxt_st.blk.block = {q_in.data, 64'h0};
                nxt_st.blk.mask = {qmask, 64'h0}; // RQ21
              end
              nxt_st.blk.start = (st_ff.iv.iv_block_field == eciv_pkg::BLK_RST);
              nxt_st.iv.iv_block_field = st_ff.iv.iv_block_field + 16'h1; // RQ22
              nxt_st.half = 1'b0;
              nxt_st.in_env = !q_in.last;
            end
          end
        end
        default:
        begin
          // bypass kinds leave alignment untouched
          nxt_st.pass = {1'b1, q_in.kind, q_in.ctrl, q_in.data}; // RQ10 RQ11 RQ12
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign blk_out = st_ff.blk;
  assign pass_out = st_ff.pass;
  assign cipher_out = st_ff.cout;
  assign cipher_out_valid = st_ff.cvalid;
  assign local_marker = st_ff.mark;
  assign local_time = st_ff.clk_a[eciv_pkg::LT_W-1:0];
  assign cipher_clock_a = st_ff.clk_a;
endmodule // eciv_core

//--- testbench/eciv_ks_model.sv
`timescale 1ns/1ns
module eciv_ks_model
#(
  parameter logic [127:0] KS = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
)
(
  input wire logic blk_valid,
  input wire logic stall,
  output logic [127:0] keystream,
  output logic keystream_valid
);
  // keystream only for a live block; the inverse pattern when not offered
  assign keystream_valid = blk_valid & ~stall;
  assign keystream = keystream_valid ? KS : ~KS;
endmodule // eciv_ks_model

//--- testbench/eciv_core_chk_sva.sv
`timescale 1ns/1ns
module eciv_core_chk
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire eciv_pkg::eciv_quantum_t q_in,
  input wire logic [127:0] keystream,
  input wire logic keystream_valid,
  input wire eciv_pkg::eciv_block_t blk_out,
  input wire eciv_pkg::eciv_pass_t pass_out,
  input wire logic [127:0] cipher_out,
  input wire logic cipher_out_valid,
  input wire logic [31:0] local_time
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_HDR: assert property (q_in.valid && q_in.kind == eciv_pkg::ECIV_Q_HEADER |=>
    pass_out.valid && pass_out.data == $past(q_in.data)) else $error("header lost");
  AST_RA: assert property (q_in.valid && q_in.kind == eciv_pkg::ECIV_Q_RATE_ADJUST |=>
    pass_out.valid && pass_out.data == $past(q_in.data)) else $error("rate adjust lost");
  AST_IDLE: assert property (q_in.valid && q_in.kind inside {eciv_pkg::ECIV_Q_IEI,
    eciv_pkg::ECIV_Q_IBI} |=> pass_out.valid) else $error("idle lost");
  AST_PAY: assert property (q_in.valid && q_in.kind == eciv_pkg::ECIV_Q_PAYLOAD |=>
    !pass_out.valid) else $error("payload bypassed");
  AST_XOR: assert property (blk_out.valid && keystream_valid |=> cipher_out_valid &&
    cipher_out == ($past(blk_out.block) ^ ($past(keystream) & $past(blk_out.mask))))
    else $error("cipher out wrong");
  AST_TICK: assert property (1'b1 |=> local_time == $past(local_time) + 32'h1)
    else $error("time not counting");
  AST_BLK0: assert property (blk_out.valid && blk_out.start |->
    blk_out.iv.iv_block_field == 16'h0) else $error("start index");
  AST_HALF: assert property (blk_out.valid && blk_out.single |->
    blk_out.mask[63:0] == 64'h0) else $error("single mask");
  cover property (blk_out.valid && blk_out.single);
  cover property (blk_out.valid && !blk_out.start);
  cover property (cipher_out_valid);
endmodule // eciv_core_chk
bind eciv_core eciv_core_chk chk_u (.*);

//--- testbench/envelope_cipher_iv_and_mask_tb.sv
`timescale 1ns/1ns
module envelope_cipher_iv_and_mask_tb;
  localparam logic [127:0] KS = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [63:0] A = 64'h0123456789abcdef;
  localparam logic [63:0] B = 64'h112233445566fd07;
  localparam logic [63:0] I = 64'h0707070707070707;
  localparam eciv_pkg::eciv_qkind_t KH = eciv_pkg::ECIV_Q_HEADER;
  localparam eciv_pkg::eciv_qkind_t KP = eciv_pkg::ECIV_Q_PAYLOAD;
  logic core_clk, nrst, mac_wr, rx_ld, tx_ld, stall, cov, ksv;
  eciv_pkg::eciv_role_t role;
  logic [47:0] mac_a, mac_b, clk_a, tm;
  logic [5:0] mk;
  logic [31:0] lt;
  logic [127:0] ks, co;
  eciv_pkg::eciv_quantum_t q;
  eciv_pkg::eciv_block_t blk, b;
  eciv_pkg::eciv_block_t bq[$];
  logic [127:0] cq[$];
  int errors, compares, cyc;
  eciv_core dut_u (.core_clk(core_clk), .nrst(nrst), .role(role), .own_mac(mac_a),
    .learned_headend_mac(mac_b), .mac_wr(mac_wr), .mac_wr_llid(4'h5), .mac_wr_data(~mac_b),
    .rx_clock_load(rx_ld), .rx_clock_value(48'h0), .tx_ext_load(tx_ld),
    .tx_ext_value(16'h00a5), .q_in(q), .keystream(ks), .keystream_valid(ksv), .blk_out(blk),
    .pass_out(), .cipher_out(co), .cipher_out_valid(cov), .local_marker(mk), .local_time(lt),
    .cipher_clock_a(clk_a));
  eciv_ks_model #(.KS(KS)) ks_u (.blk_valid(blk.valid), .stall(stall), .keystream(ks),
    .keystream_valid(ksv));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (blk.valid) bq.push_back(blk);
    if (cov) cq.push_back(co);
    if (cyc == 3000)
    begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(logic [127:0] a, logic [127:0] x);
    compares++;
    if (a !== x) $display("[ERR] %0t got %h exp %h", $time, a, x);
    if (a !== x) errors++;
  endtask
  task automatic snd(eciv_pkg::eciv_qkind_t k, logic l, logic [7:0] c, logic [63:0] d);
    @(posedge core_clk) q <= '{1'b1, k, 4'h3, 4'h5, l, c, d};
    if (k == KH) @(negedge core_clk) tm = clk_a;
  endtask
  task automatic fin;
    @(posedge core_clk) q <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_even;
    @(posedge core_clk) tx_ld <= 1'b1;
    @(posedge core_clk) tx_ld <= 1'b0;
    snd(KH, 1'b0, 8'h00, A);
    chk(clk_a[47:32], 16'h00a5);
    chk(mk, clk_a[5:0]);
    chk(lt, clk_a[31:0]);
    snd(KP, 1'b0, 8'h00, A);
    snd(eciv_pkg::ECIV_Q_RATE_ADJUST, 1'b0, 8'hff, I);
    snd(KP, 1'b1, 8'h03, B);
    fin();
    chk(bq.size(), 1);
    b = bq.pop_front();
    chk(b.iv, {4'h3, mac_a, tm, 16'h0});
    chk(b.block, {A, B});
    chk(b.mask, {64'hffffffffffffffff, 64'hffffffffffff0000});
    chk(cq.pop_front(), {A, B} ^ (KS & {64'hffffffffffffffff, 64'hffffffffffff0000}));
  endtask
  task automatic t_odd;
    @(posedge core_clk) role <= eciv_pkg::ECIV_HE_DEC;
    mac_wr <= 1'b1;
    @(posedge core_clk) mac_wr <= 1'b0;
    snd(eciv_pkg::ECIV_Q_IEI, 1'b0, 8'hff, I);
    snd(KH, 1'b0, 8'h00, B);
    snd(KP, 1'b0, 8'h00, A);
    snd(KP, 1'b0, 8'hff, I);
    snd(KP, 1'b1, 8'h7f, B);
    fin();
    chk(bq.size(), 2);
    b = bq.pop_front();
    chk(b.mask, {64'hffffffffffffffff, 64'h0});
    b = bq.pop_front();
    chk(b.iv, {4'h3, ~mac_b, tm, 16'h1});
    chk({b.single, b.block, b.mask}, {1'b1, B, 64'h0, 64'hff00000000000000, 64'h0});
    cq.delete();
  endtask
  task automatic t_term;
    snd(KP, 1'b1, 8'h00, A);
    fin();
    chk(bq.size(), 0);
    @(posedge core_clk) role <= eciv_pkg::ECIV_TE_ENC;
    snd(KH, 1'b0, 8'h00, A);
    snd(KP, 1'b1, 8'h00, A);
    snd(eciv_pkg::ECIV_Q_IBI, 1'b0, 8'hff, I);
    @(posedge core_clk) role <= eciv_pkg::ECIV_TE_DEC;
    q <= '0;
    stall <= 1'b1;
    rx_ld <= 1'b1;
    @(posedge core_clk) rx_ld <= 1'b0;
    snd(KH, 1'b0, 8'h00, A);
    snd(KP, 1'b1, 8'h00, A);
    fin();
    b = bq.pop_front();
    chk({b.start, b.iv.mac}, {1'b1, mac_a});
    b = bq.pop_front();
    chk(b.iv.mac, mac_b);
    chk(b.iv.iv_time_field, 48'h1);
    chk(cq.size(), 1);
  endtask
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    role = eciv_pkg::ECIV_HE_ENC;
    {q, mac_wr, rx_ld, tx_ld, stall} = '0;
    mac_a = 48'h0a0b0c0d0e0f;
    mac_b = 48'h102030405060;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_even();
    t_odd();
    t_term();
    complete_run();
  end
endmodule // envelope_cipher_iv_and_mask_tb
